// file: shared/axis_pkg.sv
// Constants, register map, types and helpers of the pulse axis controller.
// Assumes a 200 MHz pclk and a 32-bit APB slave port.
package axis_pkg;
  // Time base
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_MS = 20;
  localparam int unsigned SCAN_NS = 1_000_000;
  localparam int unsigned SCAN_CYC_DEF = SCAN_NS / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_CYC_DEF = CLEAR_MS * CYC_PER_MS_DEF + SCAN_CYC_DEF;
  localparam int unsigned SPEED_RATIO = 10;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_ACCUM = 8'h0C;
  localparam logic [7:0] OFF_ABS = 8'h10;
  localparam logic [7:0] OFF_TOP = 8'h14;
  localparam logic [7:0] OFF_START = 8'h18;
  localparam logic [7:0] OFF_RAMP = 8'h1C;
  localparam logic [7:0] OFF_CLRNUM = 8'h20;
  localparam logic [7:0] OFF_CREEP = 8'h24;
  localparam logic [7:0] OFF_HOMING = 8'h28;
  localparam logic [7:0] OFF_STAGE = 8'h2C;
  localparam logic [7:0] OFF_TARGET = 8'h30;
  localparam logic [7:0] OFF_CMDSPD = 8'h34;

  // Command bit positions and control word width
  localparam int unsigned CMD_POS = 0;
  localparam int unsigned CMD_SEARCH = 1;
  localparam int unsigned CMD_RETURN = 2;
  localparam int unsigned CTRL_W = 9;

  // Reset values
  localparam logic [31:0] TOP_RST = 32'h0000_2710;
  localparam logic [15:0] START_RST = 16'h0064;
  localparam logic [15:0] RAMP_RST = 16'h0064;
  localparam logic [15:0] CREEP_RST = 16'h0064;
  localparam logic [31:0] HOMING_RST = 32'h0000_03E8;

  // Envelope stage codes
  localparam logic [15:0] STAGE_IDLE = 16'h0000;
  localparam logic [15:0] STAGE_ACCEL = 16'h0001;
  localparam logic [15:0] STAGE_CONST = 16'h0002;
  localparam logic [15:0] STAGE_DECEL = 16'h0003;
  localparam logic [15:0] STAGE_CREEP = 16'h0004;
  localparam logic [15:0] STAGE_CLEAR = 16'h0005;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOME_FAST = 3'b001,
    ST_HOME_CREEP = 3'b011,
    ST_CLEAR = 3'b010,
    ST_DONE = 3'b110,
    ST_RUN = 3'b100
  } axis_state_t;

  // Control word, MSB first: stop at bit 8 down to zero_inv at bit 0
  typedef struct packed {
    logic stop;
    logic irq_en;
    logic clr_en;
    logic clr_sel;
    logic home_dir;
    logic fwd_lim;
    logic rev_lim;
    logic near_inv;
    logic zero_inv;
  } axis_ctrl_t;

  typedef struct packed {
    logic [31:0] top;
    logic [15:0] base;
    logic [15:0] ramp_ms;
    logic [15:0] creep;
    logic [31:0] homing;
  } motion_cfg_t;

  // Base must lie below a tenth of the top, command within base..top
  function automatic logic speeds_ok(input logic [15:0] base, input logic [31:0] top, input logic [31:0] cmd);
    logic [35:0] base_x;
    base_x = 36'(base) * 36'(SPEED_RATIO);
    return (base_x < 36'(top)) && (cmd >= 32'(base)) && (cmd <= top);
  endfunction

  function automatic logic [31:0] move_pos(input logic [31:0] pos, input logic [31:0] cnt, input logic fwd);
    return fwd ? pos + cnt : pos - cnt;
  endfunction
endpackage

// file: design/step_gen.sv
// Phase accumulator that turns a speed in pulses per second into a pulse train.
// Assumes speed stays below half the clock rate.
`timescale 1ns/10ps
module step_gen
  import axis_pkg::*;
#(
  parameter int unsigned CLK_RATE = CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic en,
  input wire logic [31:0] speed,
  output logic pin,
  output logic step
);
  logic [32:0] phase_reg;
  logic [32:0] phase_next;

  // Two toggles per pulse, so the phase advances by twice the speed
  always_comb begin
    phase_next = phase_reg + {speed, 1'b0};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= '0;
      pin <= 1'b0;
      step <= 1'b0;
    end else if (ce) begin
      step <= 1'b0;
      if (!en) begin
        // Dropping mid-pulse is accepted; the drive sees a short final high
        phase_reg <= '0;
        pin <= 1'b0;
      end else if (phase_next >= 33'(CLK_RATE)) begin
        phase_reg <= phase_next - 33'(CLK_RATE);
        pin <= ~pin;
        step <= ~pin;
      end else begin
        phase_reg <= phase_next;
      end
    end
  end
endmodule

// file: design/speed_ramp.sv
// Linear speed ramp: one unit of speed per total/span clock cycles.
// Assumes span never exceeds total, so at most one step per cycle.
`timescale 1ns/10ps
module speed_ramp (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic run,
  input wire logic accel,
  input wire logic [31:0] floor_speed,
  input wire logic [31:0] ceil_speed,
  input wire logic [31:0] span,
  input wire logic [31:0] total,
  output logic [31:0] speed
);
  logic [32:0] err_reg;
  logic [32:0] err_next;
  logic moving;

  always_comb begin
    err_next = err_reg + 33'(span);
    moving = accel ? (speed < ceil_speed) : (speed > floor_speed);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= '0;
      speed <= '0;
    end else if (ce) begin
      if (!run) begin
        err_reg <= '0;
        speed <= floor_speed;
      end else if (speed < floor_speed) begin
        speed <= floor_speed;
      end else if (moving) begin
        if (err_next >= 33'(total)) begin
          err_reg <= err_next - 33'(total);
          speed <= accel ? speed + 32'h0000_0001 : speed - 32'h0000_0001;
        end else begin
          err_reg <= err_next;
        end
      end else begin
        err_reg <= '0;
      end
    end
  end
endmodule

// file: design/pulse_axis_positioning_ctrl.sv
// One pulse output axis: APB registers, positioning and origin search sequencer.
// Assumes sensor and load inputs synchronous to pclk, and an APB master.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps

// What this block does
// - Update absolute position from pulses and direction on positioning runs
// - Load absolute position from drive at start-up
// - No pulses unless base below tenth of top
// - No pulses if command outside base..top
// - Origin search approaches at creep speed
// - Origin search travels at homing speed
// - Report envelope stage in read-only register
// - Stop bit disables pulse output
// - Busy flag high while channel busy
// - Completion interrupt only when enabled
// - Clear pulse only when clear enabled
// - Select bit routes clear to numbered output
// - Search direction follows direction bit
// - Limit bits mean limit reached when set
// - Near sensor polarity bit inverts input
// - Zero sensor polarity bit inverts input
// - Search busy flag high during search
// - One clear pulse, 20 ms plus scan
module pulse_axis_positioning_ctrl
  import axis_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF,
  parameter int unsigned CLEAR_CYC = CLEAR_CYC_DEF,
  parameter int unsigned CLR_N = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic abs_load_valid,
  input wire logic [31:0] abs_load_data,
  input wire logic near_in,
  input wire logic zero_in,
  output logic pulse_out,
  output logic dir_out,
  output logic default_clear_output,
  output logic [CLR_N-1:0] clear_out,
  output logic done_irq
);
  axis_ctrl_t ctrl_reg;
  motion_cfg_t cfg_reg;
  axis_state_t state_reg;
  logic [15:0] clear_num_reg;
  logic [31:0] target_reg;
  logic [31:0] cmd_speed_reg;
  logic [31:0] accum_reg;
  logic [31:0] abs_reg;
  logic [15:0] stage_reg;
  logic [31:0] dist_reg;
  logic [31:0] accel_pulses_reg;
  logic [31:0] total_reg;
  logic [31:0] clr_cnt_reg;
  logic [31:0] rdata_next;
  logic [31:0] accum_next;
  logic [31:0] speed;
  logic [31:0] floor_speed;
  logic [31:0] ceil_speed;
  logic dir_reg;
  logic decel_reg;
  logic search_reg;
  logic homing_reg;
  logic reject_reg;
  logic addr_ok;
  logic wr_en;
  logic [2:0] cmd_wr;
  logic moving;
  logic accel;
  logic step;
  logic gen_pin;
  logic near_act;
  logic zero_act;
  logic at_limit;
  logic pos_ok;
  logic home_ok;

  assign wr_en = psel && penable && pready && pwrite && addr_ok;
  assign cmd_wr = (wr_en && paddr == OFF_CMD) ? pwdata[CMD_RETURN:CMD_POS] : 3'b000;
  assign accum_next = accum_reg + 32'h0000_0001;
  assign near_act = near_in ^ ctrl_reg.near_inv;
  assign zero_act = zero_in ^ ctrl_reg.zero_inv;
  assign at_limit = dir_reg ? ctrl_reg.fwd_lim : ctrl_reg.rev_lim;
  assign moving = (state_reg == ST_RUN || state_reg == ST_HOME_FAST || state_reg == ST_HOME_CREEP)
                  && !ctrl_reg.stop;
  assign pos_ok = speeds_ok(cfg_reg.base, cfg_reg.top, cmd_speed_reg) && target_reg != '0;
  assign home_ok = speeds_ok(cfg_reg.base, cfg_reg.top, cfg_reg.homing);
  assign floor_speed = (state_reg == ST_HOME_CREEP) ? 32'(cfg_reg.creep) : 32'(cfg_reg.base);
  assign ceil_speed = (state_reg == ST_RUN) ? cmd_speed_reg : cfg_reg.homing;
  assign accel = (state_reg == ST_RUN) ? !decel_reg : (state_reg == ST_HOME_FAST);

  // Address decode and read mux
  always_comb begin
    addr_ok = 1'b1;
    rdata_next = '0;
    if (paddr == OFF_CTRL) begin
      rdata_next = 32'(ctrl_reg);
    end else if (paddr == OFF_CMD) begin
      rdata_next = '0;
    end else if (paddr == OFF_STATUS) begin
      rdata_next = {29'h0, reject_reg, homing_reg, state_reg != ST_IDLE};
    end else if (paddr == OFF_ACCUM) begin
      rdata_next = accum_reg;
    end else if (paddr == OFF_ABS) begin
      rdata_next = abs_reg;
    end else if (paddr == OFF_TOP) begin
      rdata_next = cfg_reg.top;
    end else if (paddr == OFF_START) begin
      rdata_next = 32'(cfg_reg.base);
    end else if (paddr == OFF_RAMP) begin
      rdata_next = 32'(cfg_reg.ramp_ms);
    end else if (paddr == OFF_CLRNUM) begin
      rdata_next = 32'(clear_num_reg);
    end else if (paddr == OFF_CREEP) begin
      rdata_next = 32'(cfg_reg.creep);
    end else if (paddr == OFF_HOMING) begin
      rdata_next = cfg_reg.homing;
    end else if (paddr == OFF_STAGE) begin
      rdata_next = 32'(stage_reg);
    end else if (paddr == OFF_TARGET) begin
      rdata_next = target_reg;
    end else if (paddr == OFF_CMDSPD) begin
      rdata_next = cmd_speed_reg;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // APB handshake: answer registered in the setup cycle, one wait-free access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_next;
      end
    end
  end

  // Software-owned configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
      cfg_reg <= '{top: TOP_RST, base: START_RST, ramp_ms: RAMP_RST, creep: CREEP_RST, homing: HOMING_RST};
      clear_num_reg <= '0;
      target_reg <= '0;
      cmd_speed_reg <= '0;
    end else if (ce && wr_en) begin
      if (paddr == OFF_CTRL) begin
        ctrl_reg <= axis_ctrl_t'(pwdata[CTRL_W-1:0]);
      end else if (paddr == OFF_TOP) begin
        cfg_reg.top <= pwdata;
      end else if (paddr == OFF_START) begin
        cfg_reg.base <= pwdata[15:0];
      end else if (paddr == OFF_RAMP) begin
        cfg_reg.ramp_ms <= pwdata[15:0];
      end else if (paddr == OFF_CLRNUM) begin
        clear_num_reg <= pwdata[15:0];
      end else if (paddr == OFF_CREEP) begin
        cfg_reg.creep <= pwdata[15:0];
      end else if (paddr == OFF_HOMING) begin
        cfg_reg.homing <= pwdata;
      end else if (paddr == OFF_TARGET) begin
        target_reg <= pwdata;
      end else if (paddr == OFF_CMDSPD) begin
        cmd_speed_reg <= pwdata;
      end
    end
  end

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      dir_reg <= 1'b0;
      search_reg <= 1'b0;
      homing_reg <= 1'b0;
      reject_reg <= 1'b0;
      dist_reg <= '0;
      total_reg <= '0;
      clr_cnt_reg <= '0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          total_reg <= 32'(cfg_reg.ramp_ms * CYC_PER_MS);
          clr_cnt_reg <= '0;
          if (cmd_wr[CMD_POS]) begin
            reject_reg <= !pos_ok;
            dir_reg <= !target_reg[31];
            dist_reg <= target_reg[31] ? 32'(-target_reg) : target_reg;
            if (pos_ok && !ctrl_reg.stop) begin
              state_reg <= ST_RUN;
            end
          end else if (cmd_wr[CMD_SEARCH] || cmd_wr[CMD_RETURN]) begin
            reject_reg <= !home_ok;
            dir_reg <= ctrl_reg.home_dir;
            search_reg <= cmd_wr[CMD_SEARCH];
            if (home_ok && !ctrl_reg.stop) begin
              homing_reg <= cmd_wr[CMD_SEARCH];
              state_reg <= ST_HOME_FAST;
            end
          end
        end
        ST_RUN: begin
          if (ctrl_reg.stop) begin
            state_reg <= ST_IDLE;
          end else if (step && accum_next == dist_reg) begin
            state_reg <= ST_DONE;
          end
        end
        ST_HOME_FAST: begin
          if (ctrl_reg.stop) begin
            state_reg <= ST_IDLE;
            homing_reg <= 1'b0;
          end else if (near_act) begin
            // Return stops at the near point, search creeps on to the zero point
            state_reg <= search_reg ? ST_HOME_CREEP : (ctrl_reg.clr_en ? ST_CLEAR : ST_DONE);
          end else if (at_limit) begin
            dir_reg <= ~dir_reg;
          end
        end
        ST_HOME_CREEP: begin
          if (ctrl_reg.stop) begin
            state_reg <= ST_IDLE;
            homing_reg <= 1'b0;
          end else if (zero_act) begin
            state_reg <= ctrl_reg.clr_en ? ST_CLEAR : ST_DONE;
          end else if (at_limit) begin
            dir_reg <= ~dir_reg;
          end
        end
        ST_CLEAR: begin
          clr_cnt_reg <= clr_cnt_reg + 32'h0000_0001;
          if (clr_cnt_reg == 32'(CLEAR_CYC - 1)) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          homing_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Pulse count, ramp bookkeeping and absolute position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_reg <= '0;
      abs_reg <= '0;
      accel_pulses_reg <= '0;
      decel_reg <= 1'b0;
    end else if (ce) begin
      if (state_reg == ST_IDLE && (cmd_wr[CMD_POS] || cmd_wr[CMD_SEARCH] || cmd_wr[CMD_RETURN])) begin
        accum_reg <= '0;
        accel_pulses_reg <= '0;
        decel_reg <= 1'b0;
      end else if (state_reg == ST_RUN && ctrl_reg.stop) begin
        abs_reg <= move_pos(abs_reg, accum_reg, dir_reg);
      end else if (state_reg == ST_RUN && step) begin
        accum_reg <= accum_next;
        if (accel && speed < ceil_speed) begin
          accel_pulses_reg <= accel_pulses_reg + 32'h0000_0001;
        end
        // Brake once the remaining distance is no more than the distance spent speeding up
        if (dist_reg - accum_next <= accel_pulses_reg) begin
          decel_reg <= 1'b1;
        end
        if (accum_next == dist_reg) begin
          abs_reg <= move_pos(abs_reg, accum_next, dir_reg);
        end
      end else if (moving && step) begin
        accum_reg <= accum_next;
      end else if (state_reg == ST_HOME_CREEP && zero_act) begin
        abs_reg <= '0;
      end else if (state_reg == ST_IDLE && abs_load_valid) begin
        abs_reg <= abs_load_data;
      end else if (wr_en && paddr == OFF_ACCUM) begin
        accum_reg <= pwdata;
      end else if (wr_en && paddr == OFF_ABS) begin
        abs_reg <= pwdata;
      end
    end
  end

  // Registered outputs and stage report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_out <= 1'b0;
      dir_out <= 1'b0;
      default_clear_output <= 1'b0;
      clear_out <= '0;
      done_irq <= 1'b0;
      stage_reg <= STAGE_IDLE;
    end else if (ce) begin
      pulse_out <= gen_pin && moving;
      dir_out <= dir_reg;
      default_clear_output <= state_reg == ST_CLEAR && !ctrl_reg.clr_sel;
      clear_out <= (state_reg == ST_CLEAR && ctrl_reg.clr_sel && clear_num_reg < 16'(CLR_N))
                   ? CLR_N'(1) << clear_num_reg : '0;
      done_irq <= state_reg == ST_DONE && ctrl_reg.irq_en;
      if (state_reg == ST_CLEAR) begin
        stage_reg <= STAGE_CLEAR;
      end else if (state_reg == ST_HOME_CREEP) begin
        stage_reg <= STAGE_CREEP;
      end else if (!moving) begin
        stage_reg <= STAGE_IDLE;
      end else if (state_reg == ST_RUN && decel_reg) begin
        stage_reg <= STAGE_DECEL;
      end else if (speed < ceil_speed) begin
        stage_reg <= STAGE_ACCEL;
      end else begin
        stage_reg <= STAGE_CONST;
      end
    end
  end

  speed_ramp u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(moving),
    .accel(accel),
    .floor_speed(floor_speed),
    .ceil_speed(ceil_speed),
    .span(cfg_reg.top - 32'(cfg_reg.base)),
    .total(total_reg),
    .speed(speed)
  );

  step_gen #(
    .CLK_RATE(CLK_HZ)
  ) u_gen (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .en(moving),
    .speed(speed),
    .pin(gen_pin),
    .step(step)
  );
endmodule

// file: testbench/pulse_axis_positioning_ctrl_props.sv
// Checker for the pulse axis controller ports.
// Assumes the bind below and APB writes to the control word.
`timescale 1ns/10ps
module axis_props
  import axis_pkg::*;
#(
  parameter int unsigned CLEAR_CYC = CLEAR_CYC_DEF,
  parameter int unsigned CLR_N = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pulse_out,
  input wire logic dir_out,
  input wire logic default_clear_output,
  input wire logic [CLR_N-1:0] clear_out,
  input wire logic done_irq
);
  axis_ctrl_t ctrl_reg;
  logic [31:0] hi_cnt_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control shadow, taken at the commit edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
    end else if (psel && penable && pready && pwrite && paddr == OFF_CTRL) begin
      ctrl_reg <= pwdata[CTRL_W-1:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_reg <= '0;
    end else begin
      hi_cnt_reg <= default_clear_output ? hi_cnt_reg + 32'h1 : 32'h0;
    end
  end
  // Four cycles of slack for the registered pulse path
  a_stop_no_pulse: assert property (ctrl_reg.stop && $past(ctrl_reg.stop, 4) |-> !$rose(pulse_out))
    else $error("pulse edge while stopped");
  a_irq_enabled: assert property (done_irq |-> ctrl_reg.irq_en)
    else $error("completion pulse while disabled");
  a_irq_single: assert property (done_irq |=> !done_irq)
    else $error("completion pulse too long");
  a_clear_enabled: assert property ((default_clear_output || (|clear_out)) |-> ctrl_reg.clr_en)
    else $error("clear while clear disabled");
  a_clear_default: assert property (default_clear_output |-> !ctrl_reg.clr_sel && clear_out == '0)
    else $error("default clear while routed");
  a_clear_routed: assert property ((|clear_out) |-> ctrl_reg.clr_sel && $onehot(clear_out))
    else $error("routed clear wrong");
  a_clear_width: assert property ($fell(default_clear_output) |-> hi_cnt_reg == CLEAR_CYC)
    else $error("clear pulse width wrong");
  a_dir_steady: assert property ($rose(pulse_out) |-> $stable(dir_out))
    else $error("direction moved with pulse");
  cover property ($fell(default_clear_output));
  cover property (done_irq);
  cover property (|clear_out);
endmodule

bind pulse_axis_positioning_ctrl axis_props #(.CLEAR_CYC(CLEAR_CYC), .CLR_N(CLR_N)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pulse_out(pulse_out), .dir_out(dir_out),
  .default_clear_output(default_clear_output), .clear_out(clear_out), .done_irq(done_irq));

// file: testbench/drive_model.sv
// Behavioural motor drive: counts pulses, reports home sensors.
// Assumes pulse periods of many pclk cycles.
`timescale 1ns/10ps
module drive_model #(
  parameter int NEAR_W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pulse_out,
  input wire logic dir_out,
  output int pos,
  output logic near_raw,
  output logic zero_raw
);
  logic last_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 0;
      last_reg <= 1'b0;
    end else begin
      last_reg <= pulse_out;
      if (pulse_out && !last_reg) begin
        pos <= dir_out ? pos + 1 : pos - 1;
      end
    end
  end
  // Active high; the bench adds any wiring inversion
  assign near_raw = pos >= -NEAR_W && pos <= NEAR_W;
  assign zero_raw = pos == 0;
endmodule

// file: testbench/pulse_axis_positioning_ctrl_test.sv
// Self-checking bench for the pulse axis controller.
// Assumes the drive model and checker are compiled first.
`timescale 1ns/10ps
module pulse_axis_positioning_ctrl_test;
  import axis_pkg::*;
  localparam logic [7:0] RA [7] = '{OFF_TOP, OFF_START, OFF_RAMP, OFF_CREEP, OFF_HOMING, OFF_STAGE, OFF_STATUS};
  localparam logic [31:0] RV [7] = '{TOP_RST, 32'(START_RST), 32'(RAMP_RST), 32'(CREEP_RST), HOMING_RST, 0, 0};
  localparam logic [31:0] BS [3] = '{32'h2710, 32'h26AC, 32'h26AC};
  localparam logic [31:0] CS [3] = '{32'hC350, 32'h1F40, 32'h186A1};
  logic pclk, presetn, psel, penable, pwrite, abs_load_valid, near_inv, zero_inv, serr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, abs_load_data, q, rnd;
  logic pready, pslverr, pulse_out, dir_out, default_clear_output, done_irq, near_raw, zero_raw;
  logic [15:0] clear_out;
  logic last_clr, last_sel;
  logic [3:0] clr_n;
  int pos, error_cnt, check_count, irq_cnt, clr_cnt, sel_cnt, exp_abs;

  pulse_axis_positioning_ctrl #(.CYC_PER_MS(10), .CLEAR_CYC(30), .CLR_N(16)) i_dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .abs_load_valid(abs_load_valid), .abs_load_data(abs_load_data), .near_in(near_raw ^ near_inv),
    .zero_in(zero_raw ^ zero_inv), .pulse_out(pulse_out), .dir_out(dir_out),
    .default_clear_output(default_clear_output), .clear_out(clear_out), .done_irq(done_irq));
  drive_model i_drive (.pclk(pclk), .presetn(presetn), .pulse_out(pulse_out), .dir_out(dir_out),
    .pos(pos), .near_raw(near_raw), .zero_raw(zero_raw));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    last_clr <= default_clear_output;
    last_sel <= clear_out[clr_n];
    if (done_irq === 1'b1) irq_cnt++;
    if (default_clear_output === 1'b1 && last_clr === 1'b0) clr_cnt++;
    if (clear_out[clr_n] === 1'b1 && last_sel === 1'b0) sel_cnt++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Entered just after an edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait limit of its own; a stuck slave is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_idle;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
    end while (q[1:0] !== 2'b00);
  endtask

  // Scenarios need about 60000 cycles
  initial begin
    repeat (100000) @(posedge pclk);
    error_cnt++;
    end_of_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, abs_load_valid, near_inv, zero_inv} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    abs_load_data = 32'h0;
    clr_n = 4'h0;
    rnd = 32'h34C9E93A;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (RA[i]) begin
      apb(1'b0, RA[i], 32'h0);
      chk("reset value", q, RV[i]);
    end
    apb(1'b1, 8'h3C, rnd);
    chk("unmapped error", 32'(serr), 32'h1);
    rnd = lfsr(rnd);
    abs_load_data <= rnd;
    abs_load_valid <= 1'b1;
    @(posedge pclk);
    abs_load_valid <= 1'b0;
    @(posedge pclk);
    apb(1'b0, OFF_ABS, 32'h0);
    chk("abs load", q, rnd);
    exp_abs = rnd;
    apb(1'b1, OFF_TOP, 32'h186A0);
    apb(1'b1, OFF_RAMP, 32'h32);
    apb(1'b1, OFF_CREEP, 32'hC350);
    apb(1'b1, OFF_HOMING, 32'h186A0);
    apb(1'b1, OFF_CTRL, 32'h80);
    apb(1'b1, OFF_TARGET, 32'h2);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFF_START, BS[i]);
      apb(1'b1, OFF_CMDSPD, CS[i]);
      apb(1'b1, OFF_CMD, 32'h1);
      repeat (200) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("reject status", 32'(q[2:0]), 32'h4);
      chk("reject pulses", 32'(pos), 32'h0);
    end
    apb(1'b1, OFF_START, 32'h26AC);
    apb(1'b1, OFF_CMDSPD, 32'h186A0);
    apb(1'b1, OFF_CMD, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("busy", 32'(q[0]), 32'h1);
    apb(1'b0, OFF_STAGE, 32'h0);
    chk("stage moving", 32'(q >= 1 && q <= 3), 32'h1);
    wait_idle;
    exp_abs += 2;
    chk("forward pulses", 32'(pos), 32'h2);
    apb(1'b0, OFF_ABS, 32'h0);
    chk("abs forward", q, 32'(exp_abs));
    chk("done irq", 32'(irq_cnt), 32'h1);
    near_inv <= 1'b1;
    zero_inv <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h43);
    apb(1'b1, OFF_CMD, 32'h2);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("search busy", 32'(q[1]), 32'h1);
    wait_idle;
    repeat (40) @(posedge pclk);
    chk("home position", 32'(pos), 32'h0);
    apb(1'b0, OFF_ABS, 32'h0);
    chk("abs at zero", q, 32'h0);
    exp_abs = 0;
    chk("default clear", 32'(clr_cnt), 32'h1);
    apb(1'b1, OFF_CTRL, 32'h100);
    apb(1'b1, OFF_TARGET, 32'hFFFFFFFD);
    apb(1'b1, OFF_CMD, 32'h1);
    repeat (3000) @(posedge pclk);
    chk("stopped pulses", 32'(pos), 32'h0);
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_CMD, 32'h1);
    wait_idle;
    exp_abs -= 3;
    chk("reverse pulses", 32'(pos), 32'(exp_abs));
    apb(1'b0, OFF_ABS, 32'h0);
    chk("abs reverse", q, 32'(exp_abs));
    chk("masked irq", 32'(irq_cnt), 32'h1);
    rnd = lfsr(rnd);
    clr_n <= rnd[3:0];
    near_inv <= 1'b0;
    zero_inv <= 1'b0;
    apb(1'b1, OFF_CLRNUM, 32'(rnd[3:0]));
    apb(1'b1, OFF_CTRL, 32'h70);
    apb(1'b1, OFF_CMD, 32'h4);
    wait_idle;
    repeat (40) @(posedge pclk);
    chk("return stop", 32'(pos), 32'hFFFFFFFE);
    chk("routed clear", 32'(sel_cnt), 32'h1);
    chk("default clear quiet", 32'(clr_cnt), 32'h1);
    end_of_test;
  end
endmodule
